// ### hdl/program_store_defines.vh
// Constants shared by the program store and table read logic.
`ifndef PROGRAM_STORE_DEFINES_VH
`define PROGRAM_STORE_DEFINES_VH

// Store organisations selectable by device variant.
`define VARIANT_1K_BY_14   2'h0
`define VARIANT_2K_BY_14   2'h1
`define VARIANT_4K_BY_15   2'h2

// Address and word widths for each organisation.
`define AW_1K              10
`define AW_2K              11
`define AW_4K              12
`define WW_14              14
`define WW_15              15

// Fixed program addresses for reset and the three interrupt sources.
`define VEC_RESET          12'h000
`define VEC_EXT            12'h004
`define VEC_TMR            12'h008
`define VEC_ADC            12'h00C

// Data memory addresses of the two table registers.
`define ADDR_TABLE_PTR     8'h07
`define ADDR_TABLE_HIGH    8'h08

// Reset values of the table registers.
`define RST_TABLE_PTR      8'h00
`define RST_TABLE_HIGH     8'h00

// Number of low address bits that the table pointer supplies.
`define TABLE_LOW_BITS     8

// Source indices inside the interrupt request vector.
`define SRC_EXT            0
`define SRC_TMR            1
`define SRC_ADC            2

`endif

// ### hdl/program_word_store.v
// Word-organised program store with a programming port and one read port.
`timescale 1ns/1ps
module program_word_store #(
  parameter AW = 12,                    // Address width.
  parameter WW = 15                     // Word width.
) (
  input  wire          clk,             // Instruction-cycle clock.
  input  wire          prog_we,         // Programming write strobe.
  input  wire [AW-1:0] prog_addr,       // Programming address.
  input  wire [WW-1:0] prog_wdata,      // Programming data.
  input  wire [AW-1:0] rd_addr,         // Read address.
  output reg  [WW-1:0] rd_data          // Read word, one cycle later.
);

  reg [WW-1:0] words [0:(1<<AW)-1];

  // The store is written only by the programmer and read every cycle.
  always @(posedge clk) begin
    if (prog_we) begin
      words[prog_addr] <= prog_wdata;
    end
    rd_data <= words[rd_addr];
  end

endmodule

// ### hdl/vector_arbiter.v
// Fixed-priority choice among pending interrupt sources and their vectors.
`timescale 1ns/1ps
`include "program_store_defines.vh"
module vector_arbiter (
  input  wire [2:0]  pending,           // Enabled requests per source.
  input  wire        stack_full,        // Return stack has no free level.
  output reg  [2:0]  grant,             // One-hot granted source.
  output reg  [11:0] vector             // Program address of the grant.
);

  // External beats timer beats converter; nothing is granted on full stack.
  always @* begin
    grant  = 3'h0;
    vector = `VEC_RESET;
    if (stack_full) begin
      grant = 3'h0;
    end else if (pending[`SRC_EXT]) begin
      grant  = 3'h1;
      vector = `VEC_EXT;
    end else if (pending[`SRC_TMR]) begin
      grant  = 3'h2;
      vector = `VEC_TMR;
    end else if (pending[`SRC_ADC]) begin
      grant  = 3'h4;
      vector = `VEC_ADC;
    end
  end

endmodule

// ### hdl/program_store_table_read.v
// Program store fetch sequencing, vectors and table read unit.
//
// What this block does
// - Store is 1Kx14, 2Kx14 or 4Kx15 by variant.
// - Program counter fetches code, tables and vectors.
// - After reset, fetch starts at address 000H.
// - Enabled external falling edge branches to 004H.
// - Enabled timer overflow branches to 008H.
// - Enabled conversion done branches to 00CH.
// - Table pointer gives low eight table address bits.
// - Current page: upper PC bits plus pointer.
// - Last page: upper bits ones plus pointer.
// - Low table byte goes to operand register.
// - Upper word bits to latch, unused bits zero.
// - High latch is read-only, only tables change it.
// - Table read takes two instruction cycles.
// - Table address width equals program counter width.
// - Data memory side is eight bits wide.
// - Full stack keeps request, defers vector until pop.
`timescale 1ns/1ps
`include "program_store_defines.vh"
module program_store_table_read #(
  parameter VARIANT = `VARIANT_4K_BY_15 // Store organisation selector.
) (
  input  wire        clk,               // Instruction-cycle clock.
  input  wire        rst,               // Synchronous reset, active high.
  input  wire        prog_we,           // Programming write strobe.
  input  wire [11:0] prog_addr,         // Programming address.
  input  wire [14:0] prog_wdata,        // Programming word.
  input  wire        jump_valid,        // Core loads a new program address.
  input  wire [11:0] jump_addr,         // Target of jump, call or return.
  input  wire        read_table_current_page, // Current-page table read.
  input  wire        read_table_last_page,    // Last-page table read.
  input  wire [7:0]  table_dest,        // Operand register for low byte.
  input  wire        ext_int_pin,       // External interrupt pin, async.
  input  wire        tmr_overflow,      // Timer overflow pulse.
  input  wire        adc_done,          // Conversion complete pulse.
  input  wire        int_global_en,     // Global interrupt enable.
  input  wire [2:0]  int_src_en,        // Per-source enables.
  input  wire        stack_full,        // Return stack full.
  input  wire [7:0]  dm_addr,           // Data memory address.
  input  wire        dm_wr,             // Data memory write strobe.
  input  wire [7:0]  dm_wdata,          // Data memory write data.
  output reg  [7:0]  dm_rdata,          // Read data of table registers.
  output reg  [14:0] instr,             // Fetched instruction word.
  output reg  [11:0] instr_addr,        // Address of fetched word.
  output reg         instr_valid,       // Instruction word is valid.
  output reg         tab_wr,            // Low table byte write pulse.
  output reg  [7:0]  tab_wr_addr,       // Destination register.
  output reg  [7:0]  tab_wr_data,       // Low table byte.
  output reg  [7:0]  table_high_latch,  // High part of last table word.
  output reg  [7:0]  table_pointer_low, // Table pointer contents.
  output reg         int_ack,           // Vector taken, push request.
  output reg  [11:0] push_addr,         // Return address to push.
  output reg  [2:0]  int_req            // Recorded interrupt requests.
);

  // Widths that follow from the chosen organisation.
  localparam AW = (VARIANT == `VARIANT_1K_BY_14) ? `AW_1K :
                  (VARIANT == `VARIANT_2K_BY_14) ? `AW_2K : `AW_4K;
  localparam WW = (VARIANT == `VARIANT_4K_BY_15) ? `WW_15 : `WW_14;
  localparam HW = WW - `TABLE_LOW_BITS;
  localparam UW = AW - `TABLE_LOW_BITS;

  // Sequencer states.
  localparam ST_RUN   = 2'b01;
  localparam ST_TABLE = 2'b10;

  reg  [1:0]    state_reg;
  reg  [1:0]    state_next;
  reg  [AW-1:0] pc_reg;
  reg  [AW-1:0] pc_next;
  reg  [AW-1:0] rom_addr;
  reg           table_last_reg;
  reg  [7:0]    table_dest_reg;
  reg           take_int;
  reg           ext_s1_reg;
  reg           ext_s2_reg;
  reg           ext_s3_reg;
  reg           ext_lvl_reg;
  wire          ext_fall;
  wire [2:0]    src_event;
  wire [2:0]    pending;
  wire [2:0]    grant;
  wire [11:0]   vector;
  wire [WW-1:0] rom_data;
  wire [AW-1:0] table_addr_cur;
  wire [AW-1:0] table_addr_last;
  wire          table_req;
  wire [AW-1:0] one_aw;
  wire [7:0]    high_bits;
  wire [AW+11:0] addr_wide;
  wire [AW+11:0] pc_wide;
  wire [WW+14:0] word_wide;

  // Zero-extend through wide buffers so no variant needs a null repeat.
  assign addr_wide = {12'h000, rom_addr};
  assign pc_wide   = {12'h000, pc_reg};
  assign word_wide = {15'h0000, rom_data};

  assign one_aw = {{(AW-1){1'b0}}, 1'b1};

  // The program store itself, sized by the variant.
  program_word_store #(
    .AW (AW),
    .WW (WW)
  ) u_store (
    .clk        (clk),
    .prog_we    (prog_we),
    .prog_addr  (prog_addr[AW-1:0]),
    .prog_wdata (prog_wdata[WW-1:0]),
    .rd_addr    (rom_addr),
    .rd_data    (rom_data)
  );

  // The interrupt pin passes three flops; a level counts once two agree.
  always @(posedge clk) begin
    if (rst) begin
      ext_s1_reg  <= 1'b1;
      ext_s2_reg  <= 1'b1;
      ext_s3_reg  <= 1'b1;
      ext_lvl_reg <= 1'b1;
    end else begin
      ext_s1_reg <= ext_int_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg) begin
        ext_lvl_reg <= ext_s3_reg;
      end
    end
  end

  // A falling edge of the filtered pin raises the external request.
  assign ext_fall = ext_lvl_reg & ~ext_s2_reg & ~ext_s3_reg;

  assign src_event = {adc_done, tmr_overflow, ext_fall};

  // Only requests that are enabled compete for the vector.
  assign pending = int_req & int_src_en & {3{int_global_en}};

  vector_arbiter u_arb (
    .pending    (pending),
    .stack_full (stack_full),
    .grant      (grant),
    .vector     (vector)
  );

  // Requests are sticky; a new event wins over the clear of its own grant.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_req
      always @(posedge clk) begin
        if (rst) begin
          int_req[gi] <= 1'b0;
        end else if (src_event[gi]) begin
          int_req[gi] <= 1'b1;
        end else if (take_int && grant[gi]) begin
          int_req[gi] <= 1'b0;          // Held while stack is full.
        end
      end
    end
  endgenerate

  // Table addresses from the pointer and either page selection.
  assign table_addr_cur  = {pc_reg[AW-1:`TABLE_LOW_BITS],
                            table_pointer_low};
  assign table_addr_last = {{UW{1'b1}}, table_pointer_low};
  assign table_req = read_table_current_page | read_table_last_page;

  // Address selection: table access, jump, vector, then next in line.
  always @* begin
    state_next = state_reg;
    pc_next    = pc_reg;
    rom_addr   = pc_reg;
    take_int   = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (table_req) begin
          // The table word takes the slot of the next fetch.
          rom_addr   = read_table_last_page ? table_addr_last
                                            : table_addr_cur;
          state_next = ST_TABLE;
        end else if (jump_valid) begin
          rom_addr = jump_addr[AW-1:0];
          pc_next  = jump_addr[AW-1:0] + one_aw;
        end else if (grant != 3'h0) begin
          take_int = 1'b1;
          rom_addr = vector[AW-1:0];
          pc_next  = vector[AW-1:0] + one_aw;
        end else begin
          pc_next = pc_reg + one_aw;
        end
      end
      ST_TABLE: begin
        // Second cycle of the table read: the held fetch resumes.
        rom_addr   = pc_reg;
        pc_next    = pc_reg + one_aw;
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Reset parks the counter at the reset vector for the first fetch.
  always @(posedge clk) begin
    if (rst) begin
      state_reg      <= ST_RUN;
      pc_reg         <= {AW{1'b0}};
      table_last_reg <= 1'b0;
      table_dest_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      if (state_reg == ST_RUN && table_req) begin
        table_last_reg <= read_table_last_page;
        table_dest_reg <= table_dest;
      end
    end
  end

  // Fetch outputs; the word read during a table slot is not an opcode.
  always @(posedge clk) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr_addr  <= 12'h000;
      int_ack     <= 1'b0;
      push_addr   <= 12'h000;
    end else begin
      instr_valid <= ~(state_reg == ST_RUN && table_req);
      instr_addr  <= addr_wide[11:0];
      int_ack     <= take_int;
      push_addr   <= pc_wide[11:0];
    end
  end

  // The word width is fixed by the variant; pad the top with zeros.
  always @* begin
    instr = word_wide[14:0];
  end

  // Upper word bits for the latch; positions beyond the word read zero.
  assign high_bits = {{(8-HW){1'b0}}, rom_data[WW-1:`TABLE_LOW_BITS]};

  // Table data lands at the end of the second table cycle.
  always @(posedge clk) begin
    if (rst) begin
      tab_wr           <= 1'b0;
      tab_wr_addr      <= 8'h00;
      tab_wr_data      <= 8'h00;
      table_high_latch <= `RST_TABLE_HIGH;
    end else begin
      tab_wr <= (state_reg == ST_TABLE);
      if (state_reg == ST_TABLE) begin
        tab_wr_addr      <= table_dest_reg;
        tab_wr_data      <= rom_data[7:0];
        table_high_latch <= high_bits;
      end
    end
  end

  // The pointer is written by software, or by a table byte aimed at it.
  always @(posedge clk) begin
    if (rst) begin
      table_pointer_low <= `RST_TABLE_PTR;
    end else if (tab_wr && tab_wr_addr == `ADDR_TABLE_PTR) begin
      table_pointer_low <= tab_wr_data;
    end else if (dm_wr && dm_addr == `ADDR_TABLE_PTR) begin
      table_pointer_low <= dm_wdata;
    end
  end

  // Register reads; writes to the latch address have no effect.
  always @(posedge clk) begin
    if (rst) begin
      dm_rdata <= 8'h00;
    end else if (dm_addr == `ADDR_TABLE_PTR) begin
      dm_rdata <= table_pointer_low;
    end else if (dm_addr == `ADDR_TABLE_HIGH) begin
      dm_rdata <= table_high_latch;
    end else begin
      dm_rdata <= 8'h00;
    end
  end

  // Table reads from interrupt handlers may overwrite the latch; the
  // main program masks interrupts around its own table reads.

endmodule

// ### test/return_stack_model.sv
// Return stack model on the core side that flags a full stack.
`timescale 1ns/1ps
module return_stack_model #(
  parameter DEPTH = 1          // Stack levels.
) (
  input  wire clk,             // Clock.
  input  wire rst,             // Reset.
  input  wire push,            // Vector taken.
  input  wire pop,             // Return instruction.
  output wire stack_full       // No free level.
);
  reg [3:0] level_reg;
  // Pushes and pops move the level; a full stack holds vectors off.
  always @(posedge clk) begin
    if (rst)
      level_reg <= 4'h0;
    else if (push && !pop)
      level_reg <= level_reg + 4'h1;
    else if (pop && !push && level_reg != 4'h0)
      level_reg <= level_reg - 4'h1;
  end
  assign stack_full = (level_reg >= DEPTH);
endmodule

// ### test/program_store_table_read_properties.sv
// Checker of fetch, table read, register and vector timing.
`timescale 1ns/1ps
module program_store_checks (
  input wire        clk,                     // Clock.
  input wire        rst,                     // Reset.
  input wire        jump_valid,              // Jump strobe.
  input wire [11:0] jump_addr,               // Jump target.
  input wire        read_table_current_page, // Current-page read.
  input wire        read_table_last_page,    // Last-page read.
  input wire [7:0]  table_dest,              // Destination.
  input wire        stack_full,              // Stack full.
  input wire [7:0]  dm_addr,                 // Register address.
  input wire        dm_wr,                   // Register write.
  input wire [7:0]  dm_wdata,                // Write data.
  input wire [7:0]  dm_rdata,                // Read data.
  input wire [11:0] instr_addr,              // Fetch address.
  input wire        instr_valid,             // Fetch valid.
  input wire        tab_wr,                  // Low byte strobe.
  input wire [7:0]  tab_wr_addr,             // Low byte target.
  input wire [7:0]  table_high_latch,        // High latch.
  input wire [7:0]  table_pointer_low,       // Pointer.
  input wire        int_ack                  // Vector taken.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire tab_req = read_table_current_page || read_table_last_page;
  sequence gap_s; !instr_valid && !tab_wr; endsequence
  sequence done_s; tab_wr && instr_valid; endsequence
  reset_fetch_a: assert property ($fell(rst) |=> instr_valid
    && instr_addr == 12'h000) else $error("no fetch of 000 after reset");
  jump_target_a: assert property (jump_valid && !tab_req &&
    !$past(tab_req) |=> instr_valid && instr_addr == $past(jump_addr))
    else $error("jump target not fetched");
  table_steps_a: assert property (tab_req && !$past(tab_req)
    |=> gap_s ##1 done_s) else $error("table read steps wrong");
  table_dest_a: assert property (tab_wr |->
    tab_wr_addr == $past(table_dest, 2)) else $error("table dest wrong");
  latch_source_a: assert property (!$past(rst) &&
    $changed(table_high_latch) |-> tab_wr) else $error("latch changed");
  latch_top_a: assert property (table_high_latch[7] == 1'b0)
    else $error("unused latch bit set");
  full_hold_a: assert property ($past(stack_full) |-> !int_ack)
    else $error("vector taken on full stack");
  ack_vector_a: assert property (int_ack |-> instr_valid &&
    (instr_addr == 12'h004 || instr_addr == 12'h008 ||
    instr_addr == 12'h00C)) else $error("bad vector");
  ptr_write_a: assert property (dm_wr && dm_addr == 8'h07 &&
    !(tab_wr && tab_wr_addr == 8'h07) |=>
    table_pointer_low == $past(dm_wdata)) else $error("pointer write lost");
  reg_read_a: assert property (dm_addr == 8'h07 |=>
    dm_rdata == $past(table_pointer_low)) else $error("pointer read wrong");
endmodule
bind program_store_table_read program_store_checks chk_u (.clk(clk),
  .rst(rst), .jump_valid(jump_valid), .jump_addr(jump_addr),
  .read_table_current_page(read_table_current_page),
  .read_table_last_page(read_table_last_page), .table_dest(table_dest),
  .stack_full(stack_full), .dm_addr(dm_addr), .dm_wr(dm_wr),
  .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .instr_addr(instr_addr),
  .instr_valid(instr_valid), .tab_wr(tab_wr), .tab_wr_addr(tab_wr_addr),
  .table_high_latch(table_high_latch),
  .table_pointer_low(table_pointer_low), .int_ack(int_ack));

// ### test/program_store_table_read_bench.sv
// Self-checking bench for the program store and table read block.
`timescale 1ns/1ps
module program_store_table_read_bench;
  reg         clk = 1'b0, rst = 1'b1, prog_we = 1'b0, jump_valid = 1'b0;
  reg         rtc = 1'b0, rtl = 1'b0, ext_pin = 1'b1, tmr = 1'b0;
  reg         adc = 1'b0, gen = 1'b0, dm_wr = 1'b0, pop = 1'b0;
  reg  [11:0] prog_addr = 12'h000, jump_addr = 12'h000, x, a;
  reg  [14:0] prog_wdata = 15'h0000, w;
  reg  [7:0]  table_dest = 8'h80, dm_addr = 8'h00, dm_wdata = 8'h00;
  reg  [7:0]  pv = 8'h00;
  wire [11:0] push;
  reg  [2:0]  src_en = 3'h0;
  wire [7:0]  dm_rdata, tab_wr_addr, tab_wr_data, latch, ptr;
  wire [14:0] instr;
  wire [11:0] instr_addr;
  wire [2:0]  int_req;
  wire        instr_valid, tab_wr, int_ack, stack_full;
  reg  [14:0] mem [0:4095];
  integer     bad_count = 0, checks = 0, i, n;
  program_store_table_read dut_u (.clk(clk), .rst(rst), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .jump_valid(jump_valid),
    .jump_addr(jump_addr), .read_table_current_page(rtc),
    .read_table_last_page(rtl), .table_dest(table_dest),
    .ext_int_pin(ext_pin), .tmr_overflow(tmr), .adc_done(adc),
    .int_global_en(gen), .int_src_en(src_en), .stack_full(stack_full),
    .dm_addr(dm_addr), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata), .instr(instr), .instr_addr(instr_addr),
    .instr_valid(instr_valid), .tab_wr(tab_wr), .tab_wr_addr(tab_wr_addr),
    .tab_wr_data(tab_wr_data), .table_high_latch(latch),
    .table_pointer_low(ptr), .int_ack(int_ack), .push_addr(push),
    .int_req(int_req));
  return_stack_model stack_u (.clk(clk), .rst(rst), .push(int_ack),
    .pop(pop), .stack_full(stack_full));
  // Clock of 25 ns period.
  always #12.5 clk = ~clk;
  // Compare and count.
  task check(input [31:0] seen, input [31:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task step(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task conclude;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Table address: upper bits from the next fetch address or all ones.
  function [11:0] taddr(input last, input [11:0] pc, input [7:0] t);
    taddr = {last ? 4'hF : pc[11:8], t};
  endfunction
  task reg_write(input [7:0] ad, input [7:0] d);
    begin
      dm_addr = ad; dm_wdata = d; dm_wr = 1'b1;
      step(1);
      dm_wr = 1'b0;
    end
  endtask
  task jump(input [11:0] j);
    begin
      jump_addr = j; jump_valid = 1'b1;
      step(1);
      jump_valid = 1'b0;
    end
  endtask
  // One table read, checked step by step.
  task table_read(input last);
    begin
      x = instr_addr + 12'h001;
      w = mem[taddr(last, x, pv)];
      table_dest = $urandom | 8'h80;
      rtc = !last; rtl = last;
      step(1);
      rtc = 1'b0; rtl = 1'b0;
      check(instr_valid, 1'b0);
      step(1);
      check(tab_wr, 1'b1);
      check(tab_wr_data, w[7:0]);
      check(tab_wr_addr, table_dest);
      check(latch, {1'b0, w[14:8]});
      check(instr_addr, x);
      step(2);
    end
  endtask
  // Wait a bounded time for a vector, then check its address.
  task take_vector(input [11:0] v);
    begin
      n = 0;
      x = instr_addr + 12'h001;
      while (int_ack !== 1'b1 && n < 20) begin
        x = instr_addr + 12'h001;
        step(1);
        n = n + 1;
      end
      check(instr_addr, v);
      check(push, x);
      step(1);
    end
  endtask
  initial begin
    #(25 * 20000);
    bad_count = bad_count + 1;
    conclude;
  end
  initial begin
    i = $urandom(98067);
    step(5);
    rst = 1'b0;
    step(1);
    check(instr_addr, 12'h000);
    check(instr_valid, 1'b1);
    for (i = 0; i < 4096; i = i + 1) begin
      prog_addr = i; prog_wdata = $urandom; mem[i] = prog_wdata;
      prog_we = 1'b1;
      step(1);
    end
    prog_we = 1'b0;
    a = $urandom & 12'hEFF;
    jump(a);
    for (i = 0; i < 8; i = i + 1) begin
      check(instr_addr, a + i);
      check(instr, mem[a + i]);
      step(1);
    end
    // Interrupts stay masked around these main-program table reads.
    for (i = 0; i < 6; i = i + 1) begin
      pv = (i == 5) ? 8'hFF : $urandom;
      reg_write(8'h07, pv);
      step(1);
      check(dm_rdata, pv);
      table_read(i[0]);
    end
    jump(12'h1FE);
    step(1);
    table_read(1'b0);
    reg_write(8'h08, ~{1'b0, w[14:8]});
    step(1);
    check(dm_rdata, {1'b0, w[14:8]});
    dm_addr = 8'h30;
    step(1);
    check(dm_rdata, 8'h00);
    gen = 1'b1; src_en = 3'h7; tmr = 1'b1;
    step(1);
    tmr = 1'b0;
    take_vector(12'h008);
    adc = 1'b1;
    step(1);
    adc = 1'b0;
    step(20);
    check(int_req[2], 1'b1);
    pop = 1'b1;
    step(1);
    pop = 1'b0;
    take_vector(12'h00C);
    pop = 1'b1;
    step(1);
    pop = 1'b0; ext_pin = 1'b0;
    take_vector(12'h004);
    ext_pin = 1'b1;
    step(2);
    conclude;
  end
endmodule
